/* File: rtl/spmi_core.sv */
// serial master core with interrupt flags and frame format control
`timescale 1ns/1ps
`default_nettype none

// interrupt request flag that stores a request arriving while set
module spmi_irq_latch (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // request and acknowledge
    input  wire logic req,
    input  wire logic ack,
    output logic      irq
);
    logic pendFf;
    logic irqFf;

    assign irq = irqFf;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irqFf  <= 1'b0;
            pendFf <= 1'b0;
        end else if (clkEn) begin
            if (req && irqFf && !ack) begin
                pendFf <= 1'b1;
            end else if (ack && pendFf) begin
                pendFf <= req;
            end
            if (req || (ack && pendFf)) begin
                irqFf <= 1'b1;
            end else if (ack) begin
                irqFf <= 1'b0;
            end
        end
    end

    a_pend_reraise: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && pendFf && ack) ##1 clkEn |-> irqFf)
        else $error("stored request not raised again after clear");
endmodule : spmi_irq_latch

module spmi_core (
    // clock, reset, enable
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clkEn,
    // control
    input  wire spmi_pkg::spmi_cfg_s cfg,
    input  wire logic [31:0]        groupIrqEnableReg,
    input  wire logic               enableSet,
    input  wire logic               enableClr,
    // data access
    input  wire logic               txWrite,
    input  wire logic [31:0]        txData,
    input  wire logic               rxRead,
    output logic [31:0]             rxData,
    // status
    input  wire spmi_pkg::spmi_flag_s flagClr,
    output spmi_pkg::spmi_flag_s    flags,
    output logic                    moduleEnable,
    output logic [31:0]             groupIrqStatusReg,
    // interrupt requests
    input  wire logic               rxIrqAck,
    input  wire logic               txIrqAck,
    output logic                    rxFullIrq,
    output logic                    txEmptyIrq,
    output logic                    groupIrq,
    output logic [7:0]              pendingVector,
    // serial link
    output logic                    sckOut,
    output logic                    mosiOut,
    output logic                    slaveSelectLine0,
    input  wire logic               misoIn,
    input  wire logic               sslIn
);
    spmi_pkg::spmi_state_e st;
    spmi_pkg::spmi_flag_s  flagFf;
    logic [31:0] txBufFf, unitBuf, shTx, rxSh, rxUnit, rxBufFf, rxDataFf, grpFf;
    logic [5:0]  bitCnt;
    logic [3:0]  divCnt;
    logic [2:0]  unitCnt;
    logic [1:0]  frameIdx, wrLane, rdLane;
    logic        enFf, txFullFf, txPar, rxPar, sckFf, mosiFf, sslFf;
    logic        misoS1, misoS2, sslS1, sslS2;
    logic        unitDone, perEvt, groupIrqFf;
    logic [7:0]  vecFf;
    logic        rxIrqW, txIrqW;

    assign flags             = flagFf;
    assign moduleEnable      = enFf;
    assign rxData            = rxDataFf;
    assign groupIrqStatusReg = grpFf;
    assign groupIrq          = groupIrqFf;
    assign pendingVector     = vecFf;
    assign sckOut            = sckFf;
    assign mosiOut           = mosiFf;
    assign slaveSelectLine0  = sslFf;

    function automatic logic [31:0] frameWord(input logic [31:0] w, input logic [1:0] i,
                                              input logic byteM);
        logic [31:0] r;
        r = byteM ? {w[{i, 3'b000} +: 8], 24'h0} : w;
        return r;
    endfunction : frameWord

    logic        byteM, halfTick, lastBit, lastFrame, lastUnit, take, modfEvt, errAny;
    logic [5:0]  lastData;
    logic [31:0] tkWord, nxWord;
    assign byteM     = cfg.byteAccessSelect;
    assign lastData  = byteM ? spmi_pkg::LAST_BIT_BYTE : spmi_pkg::LAST_BIT_WORD;
    assign lastBit   = bitCnt == (cfg.parityEnable ? lastData + 6'h1 : lastData);
    assign lastFrame = !byteM || (frameIdx == cfg.frameCount);
    assign lastUnit  = unitCnt == cfg.sequenceLength;
    assign halfTick  = divCnt == spmi_pkg::HALF_CNT;
    assign take      = enFf && txFullFf && halfTick && sckFf == 1'b0 &&
                       (st == spmi_pkg::ST_LEAD || (st == spmi_pkg::ST_LAG && !lastUnit));
    assign tkWord    = frameWord(txBufFf, 2'h0, byteM);
    assign nxWord    = frameWord(unitBuf, frameIdx + 2'h1, byteM);
    // another master pulling our select input active
    assign modfEvt   = enFf && cfg.masterMode && (sslS2 == cfg.selectLine0Polarity);
    assign errAny    = flagFf.modeFaultFlag | flagFf.overrunFlag |
                       flagFf.parityErrorFlag | flagFf.underrunFlag;

    // pin synchronisers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            misoS1 <= 1'b0;
            misoS2 <= 1'b0;
            sslS1  <= 1'b1;
            sslS2  <= 1'b1;
        end else if (clkEn) begin
            misoS1 <= misoIn;
            misoS2 <= misoS1;
            sslS1  <= sslIn;
            sslS2  <= sslS1;
        end
    end

    // module enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            enFf <= 1'b0;
        end else if (clkEn) begin
            if (enableClr || modfEvt) begin
                enFf <= 1'b0;
            end else if (enableSet) begin
                enFf <= 1'b1;
            end
        end
    end

    // transmit buffer, word or byte lanes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            txBufFf  <= spmi_pkg::WORD_RESET;
            txFullFf <= 1'b0;
            wrLane   <= 2'h0;
        end else if (clkEn) begin
            if (!enFf) begin
                txFullFf <= 1'b0;
                wrLane   <= 2'h0;
            end else if (take) begin
                txFullFf <= 1'b0;
            end else if (txWrite && !txFullFf) begin
                if (byteM) begin
                    txBufFf[{wrLane, 3'b000} +: 8] <= txData[7:0];
                    wrLane <= (wrLane == cfg.frameCount) ? 2'h0 : wrLane + 2'h1;
                    txFullFf <= wrLane == cfg.frameCount;
                end else begin
                    txBufFf  <= txData;
                    txFullFf <= 1'b1;
                end
            end
        end
    end

    a_one_frame_unit: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && enFf && !take && txWrite && !txFullFf && byteM &&
         cfg.frameCount == spmi_pkg::FC_ONE_FRAME) ##1 clkEn |-> txFullFf)
        else $error("single byte write did not fill the unit");

    // serial engine
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st       <= spmi_pkg::ST_IDLE;
            sckFf    <= 1'b0;
            mosiFf   <= 1'b0;
            sslFf    <= spmi_pkg::SSL_RESET_LVL;
            divCnt   <= 4'h0;
            bitCnt   <= 6'h0;
            frameIdx <= 2'h0;
            unitCnt  <= 3'h0;
            shTx     <= spmi_pkg::WORD_RESET;
            unitBuf  <= spmi_pkg::WORD_RESET;
            rxSh     <= spmi_pkg::WORD_RESET;
            rxUnit   <= spmi_pkg::WORD_RESET;
            txPar    <= 1'b0;
            rxPar    <= 1'b0;
            unitDone <= 1'b0;
            perEvt   <= 1'b0;
        end else if (clkEn) begin
            unitDone <= 1'b0;
            perEvt   <= 1'b0;
            divCnt   <= (halfTick || st == spmi_pkg::ST_IDLE) ? 4'h0 : divCnt + 4'h1;
            if (take) begin
                unitBuf  <= txBufFf;
                shTx     <= tkWord;
                mosiFf   <= tkWord[31];
                txPar    <= ^tkWord;
                rxPar    <= 1'b0;
                bitCnt   <= 6'h0;
                frameIdx <= 2'h0;
                unitCnt  <= (st == spmi_pkg::ST_LAG) ? unitCnt + 3'h1 : 3'h0;
                st       <= spmi_pkg::ST_BIT;
            end else if (!enFf) begin
                st    <= spmi_pkg::ST_IDLE;
                sckFf <= 1'b0;
                sslFf <= ~cfg.selectLine0Polarity;
            end else begin
                case (st)
                    spmi_pkg::ST_IDLE: begin
                        sslFf <= ~cfg.selectLine0Polarity;
                        if (cfg.mosiIdleValueEnable) begin
                            mosiFf <= cfg.mosiIdleValue;        // else held
                        end
                        if (cfg.masterMode && txFullFf) begin
                            sslFf <= cfg.selectLine0Polarity;
                            st    <= spmi_pkg::ST_LEAD;
                        end
                    end
                    spmi_pkg::ST_LEAD: begin
                        st <= spmi_pkg::ST_LEAD;
                    end
                    spmi_pkg::ST_BIT: begin
                        if (halfTick && !sckFf) begin
                            sckFf <= 1'b1;
                            if (bitCnt > lastData) begin
                                perEvt <= misoS2 != rxPar;
                            end else begin
                                rxSh  <= {rxSh[30:0], misoS2};
                                rxPar <= rxPar ^ misoS2;
                            end
                        end else if (halfTick) begin
                            sckFf <= 1'b0;
                            if (lastBit) begin
                                if (byteM) begin
                                    rxUnit[{frameIdx, 3'b000} +: 8] <= rxSh[7:0];
                                end else begin
                                    rxUnit <= rxSh;
                                end
                                if (lastFrame) begin
                                    unitDone <= 1'b1;
                                    st       <= spmi_pkg::ST_LAG;
                                end else begin
                                    frameIdx <= frameIdx + 2'h1;
                                    shTx     <= nxWord;
                                    mosiFf   <= nxWord[31];
                                    txPar    <= ^nxWord;
                                    rxPar    <= 1'b0;
                                    bitCnt   <= 6'h0;
                                end
                            end else begin
                                bitCnt <= bitCnt + 6'h1;
                                shTx   <= {shTx[30:0], 1'b0};
                                mosiFf <= (bitCnt == lastData) ? txPar : shTx[30];
                            end
                        end
                    end
                    spmi_pkg::ST_LAG: begin
                        if (halfTick) begin
                            sslFf <= ~cfg.selectLine0Polarity;
                            st    <= spmi_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        st <= spmi_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    a_disable_empties: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && !enFf) ##1 clkEn |-> !txFullFf && st == spmi_pkg::ST_IDLE)
        else $error("disable did not halt engine and empty buffer");
    a_mosi_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && st == spmi_pkg::ST_IDLE && !cfg.mosiIdleValueEnable) ##1 clkEn
        |-> mosiFf == $past(mosiFf))
        else $error("mosi moved while select negated");
    a_ssl_negated: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && st == spmi_pkg::ST_IDLE && !(cfg.masterMode && txFullFf)) ##1 clkEn
        |-> sslFf == ~$past(cfg.selectLine0Polarity))
        else $error("select line not at negated level");
    a_no_parity_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && st == spmi_pkg::ST_BIT && !cfg.parityEnable) |-> bitCnt <= lastData)
        else $error("parity bit sent while parity off");
    a_mode_fault_flag_disables: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && modfEvt) ##1 clkEn |-> !enFf && flagFf.modeFaultFlag)
        else $error("mode fault did not clear enable");

    // status flags, a set always wins over a clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flagFf   <= '0;
            rxBufFf  <= spmi_pkg::WORD_RESET;
            rxDataFf <= spmi_pkg::WORD_RESET;
            rdLane   <= 2'h0;
        end else if (clkEn) begin
            flagFf.txEmptyFlag <= !txFullFf;
            flagFf.underrunFlag <= 1'b0;                        // master only
            if (unitDone && !flagFf.rxFullFlag) begin
                rxBufFf           <= rxUnit;
                flagFf.rxFullFlag <= 1'b1;
                rdLane            <= 2'h0;
            end else if (rxRead && flagFf.rxFullFlag) begin
                rxDataFf <= byteM ? {24'h0, rxBufFf[{rdLane, 3'b000} +: 8]} : rxBufFf;
                rdLane   <= rdLane + 2'h1;
                if (!byteM || rdLane == cfg.frameCount) begin
                    flagFf.rxFullFlag <= 1'b0;
                end
            end else if (flagClr.rxFullFlag) begin
                flagFf.rxFullFlag <= 1'b0;
            end
            if (unitDone && flagFf.rxFullFlag) begin
                flagFf.overrunFlag <= 1'b1;
            end else if (flagClr.overrunFlag) begin
                flagFf.overrunFlag <= 1'b0;
            end
            if (modfEvt) begin
                flagFf.modeFaultFlag <= 1'b1;
            end else if (flagClr.modeFaultFlag) begin
                flagFf.modeFaultFlag <= 1'b0;
            end
            if (perEvt) begin
                flagFf.parityErrorFlag <= 1'b1;
            end else if (flagClr.parityErrorFlag) begin
                flagFf.parityErrorFlag <= 1'b0;
            end
            // idle stands in for a transmit-end event
            if (enFf && st == spmi_pkg::ST_IDLE && !txFullFf) begin
                flagFf.idleFlag <= 1'b1;
            end else if (flagClr.idleFlag) begin
                flagFf.idleFlag <= 1'b0;
            end
        end
    end

    a_udr_never: assert property (@(posedge mclk) disable iff (sys_rst)
        !flagFf.underrunFlag)
        else $error("underrun flag set in master operation");
    a_idle_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && !flagFf.idleFlag) ##1 (clkEn && flagFf.idleFlag)
        |-> $past(st) == spmi_pkg::ST_IDLE && !$past(txFullFf))
        else $error("idle flag set during transfer");

    // requests for vectors 038 and 039
    spmi_irq_latch u_rxIrq (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .req     (unitDone && !flagFf.rxFullFlag && cfg.rxFullIrqEnable),
        .ack     (rxIrqAck),
        .irq     (rxIrqW)
    );
    spmi_irq_latch u_txIrq (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .req     (take && cfg.txEmptyIrqEnable),
        .ack     (txIrqAck),
        .irq     (txIrqW)
    );
    assign rxFullIrq  = rxIrqW;
    assign txEmptyIrq = txIrqW;

    // grouped idle and error requests, vector 112
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            grpFf      <= spmi_pkg::WORD_RESET;
            groupIrqFf <= 1'b0;
            vecFf      <= spmi_pkg::VEC_NONE;
        end else if (clkEn) begin
            grpFf[spmi_pkg::GRP_IDLE_BIT] <= flagFf.idleFlag &&
                (grpFf[spmi_pkg::GRP_IDLE_BIT] || (cfg.idleIrqEnable &&
                 groupIrqEnableReg[spmi_pkg::GRP_IDLE_BIT]));
            grpFf[spmi_pkg::GRP_ERR_BIT] <= errAny &&
                (grpFf[spmi_pkg::GRP_ERR_BIT] || (cfg.errorIrqEnable &&
                 groupIrqEnableReg[spmi_pkg::GRP_ERR_BIT]));
            groupIrqFf <= grpFf[spmi_pkg::GRP_IDLE_BIT] || grpFf[spmi_pkg::GRP_ERR_BIT];
            vecFf <= rxIrqW ? spmi_pkg::VEC_RX_FULL :
                     txIrqW ? spmi_pkg::VEC_TX_EMPTY :
                     groupIrqFf ? spmi_pkg::VEC_GROUP : spmi_pkg::VEC_NONE;
        end
    end

    a_idle_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && !cfg.idleIrqEnable && !grpFf[spmi_pkg::GRP_IDLE_BIT]) ##1 clkEn
        |-> !grpFf[spmi_pkg::GRP_IDLE_BIT])
        else $error("idle request raised while disabled");
    a_grp_auto_clr: assert property (@(posedge mclk) disable iff (sys_rst)
        (clkEn && !errAny) ##1 clkEn |-> !grpFf[spmi_pkg::GRP_ERR_BIT])
        else $error("group error bit kept after flags cleared");

endmodule : spmi_core
`default_nettype wire

/* File: rtl/spmi_pkg.sv */
// constants and types shared by the serial master core
package spmi_pkg;

    // system clock and serial clock timing
    localparam int CLK_MHZ       = 100;
    localparam int SCK_PERIOD_NS = 125;
    // half serial period, longest time so rounded down, at least one cycle
    localparam int HALF_CYC_I    = (SCK_PERIOD_NS * CLK_MHZ) / 2000;
    localparam int HALF_CYC      = (HALF_CYC_I < 1) ? 1 : HALF_CYC_I;
    localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);

    // frame layout
    localparam logic [5:0] LAST_BIT_WORD = 6'h1f;
    localparam logic [5:0] LAST_BIT_BYTE = 6'h07;
    localparam logic [1:0] FC_ONE_FRAME  = 2'h0;
    localparam logic [2:0] SLN_ONE_UNIT  = 3'h0;

    // interrupt vectors and group bit positions
    localparam logic [7:0] VEC_RX_FULL  = 8'h26;
    localparam logic [7:0] VEC_TX_EMPTY = 8'h27;
    localparam logic [7:0] VEC_GROUP    = 8'h70;
    localparam logic [7:0] VEC_NONE     = 8'h00;
    localparam int GRP_IDLE_BIT = 16;
    localparam int GRP_ERR_BIT  = 17;

    // reset values
    localparam logic        SSL_RESET_LVL = 1'b1;
    localparam logic [31:0] WORD_RESET    = 32'h0;

    typedef struct packed {
        logic       masterMode;
        logic       mosiIdleValueEnable;
        logic       mosiIdleValue;
        logic [1:0] frameCount;
        logic       byteAccessSelect;
        logic       parityEnable;
        logic [2:0] sequenceLength;
        logic       selectLine0Polarity;
        logic       rxFullIrqEnable;
        logic       txEmptyIrqEnable;
        logic       idleIrqEnable;
        logic       errorIrqEnable;
    } spmi_cfg_s;

    typedef struct packed {
        logic rxFullFlag;
        logic txEmptyFlag;
        logic idleFlag;
        logic modeFaultFlag;
        logic overrunFlag;
        logic parityErrorFlag;
        logic underrunFlag;
    } spmi_flag_s;

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_BIT, ST_LAG} spmi_state_e;

endpackage : spmi_pkg

/* File: tb/spmi_slave_model.sv */
// serial slave partner: shifts mosi in, answers on miso
`timescale 1ns/1ps
`default_nettype none
module spmi_slave_model (
    // link
    input  wire logic        mclk,
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic        selN,
    output logic             miso,
    // bench side
    input  wire logic [31:0] reply,
    output logic [31:0]      got,
    output logic [5:0]       bits
);
    logic        ps = 1'b0;
    logic        pn = 1'b1;
    logic        mo = 1'b0;
    logic [31:0] sh = '0;
    assign miso = mo;
    always @(posedge mclk) begin
        ps <= sck;
        pn <= selN;
        if (selN) begin
            mo <= ~mo; // released line never shows a steady value
        end else if (pn) begin
            mo   <= reply[31];
            sh   <= reply << 1;
            bits <= '0;
        end else if (sck & ~ps) begin
            got  <= {got[30:0], mosi};
            bits <= bits + 6'h01;
        end else if (~sck & ps) begin
            mo   <= sh[31];
            sh   <= sh << 1;
        end
    end
endmodule : spmi_slave_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the serial master core
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 0, sys_rst = 1, enableSet = 0, enableClr = 0, txWrite = 0;
    logic rxRead = 0, rxIrqAck = 0, txIrqAck = 0, sslIn = 1;
    logic [31:0] txData = '0, gEn = '0, reply = '0, rxData, gSt, got;
    spmi_pkg::spmi_cfg_s  cfg = '0;
    spmi_pkg::spmi_flag_s flagClr = '0, flags;
    logic modEn, rxIrq, txIrq, gIrq, sck, mosi, sel, miso;
    logic [7:0] vec;
    logic [5:0] bits;
    int bad_count = 0, check_count = 0;
    always #5 mclk = ~mclk;
    spmi_core DUT (.mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1), .cfg(cfg),
        .groupIrqEnableReg(gEn), .enableSet(enableSet), .enableClr(enableClr),
        .txWrite(txWrite), .txData(txData), .rxRead(rxRead), .rxData(rxData),
        .flagClr(flagClr), .flags(flags), .moduleEnable(modEn), .groupIrqStatusReg(gSt),
        .rxIrqAck(rxIrqAck), .txIrqAck(txIrqAck), .rxFullIrq(rxIrq), .txEmptyIrq(txIrq),
        .groupIrq(gIrq), .pendingVector(vec), .sckOut(sck), .mosiOut(mosi),
        .slaveSelectLine0(sel), .misoIn(miso), .sslIn(sslIn));
    spmi_slave_model SLV (.mclk(mclk), .sck(sck), .mosi(mosi), .selN(sel), .miso(miso),
        .reply(reply), .got(got), .bits(bits));
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(logic [31:0] g, logic [31:0] e, string m);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // expected lane contents for word or byte access
    function automatic logic [31:0] lane(logic [31:0] x, logic b);
        return b ? {24'h0, x[7:0]} : x;
    endfunction : lane
    // bits seen by the slave, parity last when enabled
    function automatic logic [31:0] sent(logic [31:0] x, logic b, logic p);
        logic [31:0] r;
        r = lane(x, b);
        return p ? {r[30:0], ^r} : r;
    endfunction : sent
    // even parity error; the slave fills the parity slot from its shifter
    function automatic logic perr(logic [31:0] r, logic b, logic p);
        return p && (b ? (r[23] ^ (^r[31:24])) : (^r));
    endfunction : perr
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
        tick();
    endtask : pulse
    task automatic xfer(logic [31:0] d);
        int i;
        logic b, p, m;
        logic [31:0] e;
        b = cfg.byteAccessSelect;
        p = cfg.parityEnable;
        e = sent(d, b, p);
        m = cfg.mosiIdleValueEnable ? cfg.mosiIdleValue : e[0];
        txData = d;
        reply = $urandom;
        pulse(txWrite);
        i = 0;
        while (sel !== 1'b0 && i < 100) begin tick(); i++; end
        while (sel !== 1'b1 && i < 2000) begin tick(); i++; end
        chk(i < 2000, 1, "frame end");
        tick(20);
        chk(bits, (b ? 6'h08 : 6'h20) + 6'(p), "bits per unit");
        chk(lane(got, b), lane(e, b), "mosi data");
        chk(mosi, m, "mosi idle level");
        chk(flags.parityErrorFlag, perr(reply, b, p), "parity check");
        chk(flags.rxFullFlag, 1, "rx full");
        pulse(rxRead);
        chk(rxData, b ? {24'h0, reply[31:24]} : reply, "rx data");
        flagClr.parityErrorFlag = 1;
        tick();
        flagClr = '0;
    endtask : xfer
    initial begin
        void'($urandom(53143));
        cfg.masterMode = 1;
        cfg.rxFullIrqEnable = 1;
        cfg.txEmptyIrqEnable = 1;
        cfg.errorIrqEnable = 1;
        gEn = 32'h00030000;
        tick(20);
        sys_rst = 0;
        chk(sel, 1, "select negated high");
        chk(flags, '0, "flags after reset");
        pulse(enableSet);
        repeat (3) xfer($urandom);
        chk(vec, 8'h26, "rx vector");
        pulse(rxIrqAck);
        tick(3);
        chk(rxIrq, 1, "stored rx request");
        pulse(rxIrqAck);
        tick(3);
        chk(rxIrq, 0, "rx request gone");
        chk(vec, 8'h27, "tx vector");
        pulse(txIrqAck);
        chk(txIrq, 1, "stored tx request");
        pulse(txIrqAck);
        chk(txIrq, 0, "tx request gone");
        chk(flags.idleFlag, 1, "idle after frames");
        chk(gSt[16], 0, "idle masked");
        cfg.idleIrqEnable = 1;
        tick(3);
        chk(gSt[16], 1, "idle group bit");
        chk({gIrq, vec}, 9'h170, "group vector");
        $display("test word done");
        cfg.byteAccessSelect = 1;
        repeat (2) xfer($urandom);
        $display("test byte done");
        cfg.parityEnable = 1;
        cfg.mosiIdleValueEnable = 1;
        cfg.mosiIdleValue = 1'($urandom);
        xfer($urandom);
        cfg.mosiIdleValueEnable = 0;
        cfg.byteAccessSelect = 0;
        xfer($urandom);
        cfg.parityEnable = 0;
        cfg.byteAccessSelect = 1;
        $display("test parity done");
        txData = $urandom;
        pulse(txWrite);
        tick(60);
        pulse(enableClr);
        tick(20);
        chk({sel, modEn, flags.txEmptyFlag}, 3'b101, "disable mid frame");
        $display("test disable done");
        pulse(enableSet);
        sslIn = 0;
        tick(6);
        chk({flags.modeFaultFlag, modEn, flags.underrunFlag}, 3'b100, "mode fault");
        chk(gSt[17], 1, "error group bit");
        sslIn = 1;
        flagClr.modeFaultFlag = 1;
        tick();
        flagClr = '0;
        tick(3);
        chk(gSt[17], 0, "error group cleared");
        $display("test fault done");
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule : tb
`default_nettype wire
